// ==== dv/rscl_far_model.sv ====
/* far-side model: otp store and serial eeprom
   assumes one request outstanding per reader */
`include "rscl_consts.vh"
module rscl_far_model (
   input wire mclk, // clock
   input wire bootEep, // boot bit in otp byte 00
   input wire slow, // late answers
   input wire badCrc, // corrupt checksum
   input wire [7:0] nackAt, // refused offset, 00 none
   input wire otpReq, // otp fetch
   input wire [7:0] otpAddr, // otp offset
   output logic otpValid, // otp byte ready
   output logic [7:0] otpData, // otp byte
   input wire eepReq, // eeprom fetch
   input wire [7:0] eepAddr, // eeprom offset
   output logic eepValid, // eeprom byte ready
   output logic eepNack, // refusal
   output logic [7:0] eepData // eeprom byte
);
   timeunit 1ns;
   timeprecision 1ps;
   int oCnt = 0; // otp delay
   int eCnt = 0; // eeprom delay
   logic [7:0] oA; // held otp offset
   logic [7:0] eA; // held eeprom offset
   // stored checksum over the eeprom image, msb first
   function automatic logic [7:0] crcImg();
      logic [7:0] c;
      c = 8'h00;
      for (int a = 8; a <= 8'hB3; a++) begin
         c = c ^ (a[7:0] ^ 8'h3C);
         for (int b = 0; b < 8; b++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      end
      return c;
   endfunction
   initial begin
      otpValid = 1'b0;
      eepValid = 1'b0;
      eepNack = 1'b0;
      otpData = 8'h00;
      eepData = 8'h00;
   end
   // answers one byte per request; idle data keeps toggling
   always @(posedge mclk) begin
      otpValid <= 1'b0;
      eepValid <= 1'b0;
      eepNack <= 1'b0;
      if (otpReq) begin
         oA <= otpAddr;
         oCnt <= slow ? 6 : 1;
      end else if (oCnt > 1) begin
         oCnt <= oCnt - 1;
      end else if (oCnt == 1) begin
         oCnt <= 0;
         otpValid <= 1'b1;
         otpData <= oA == 8'h00 ? {6'h00, 1'b1, bootEep} : oA == 8'h01 ? 8'h50 : oA ^ 8'hA5;
      end else begin
         otpData <= ~otpData;
      end
      if (eepReq) begin
         eA <= eepAddr;
         eCnt <= slow ? 6 : 1;
      end else if (eCnt > 1) begin
         eCnt <= eCnt - 1;
      end else if (eCnt == 1) begin
         eCnt <= 0;
         eepNack <= eA == nackAt;
         eepValid <= eA != nackAt;
         eepData <= eA == `RSCL_EEP_CRC ? crcImg() ^ {7'h00, badCrc} : eA ^ 8'h3C;
      end else begin
         eepData <= ~eepData;
      end
   end
endmodule // rscl_far_model

// ==== dv/rscl_loader_monitor.sv ====
/* port checker of the start-up sequencer
   assumes a bind onto rscl_loader, one clock */
`include "rscl_consts.vh"
module rscl_loader_monitor #(
   parameter NDOM = 10, // domains
   parameter NOUT = 12 // outputs
) (
   input wire mclk, // clock
   input wire resetn, // reset, low
   input wire porActive, // power-up reset
   input wire external_reset_low, // reset pin
   input wire otpReq, // otp fetch
   input wire eepReq, // eeprom fetch
   input wire [7:0] eepAddr, // eeprom offset
   input wire imgWe, // image write
   input wire [7:0] imgAddr, // image address
   input wire serialEnable, // port open
   input wire pllStart, // lock start
   input wire pllLocked, // lock report
   input wire divSync, // sync pulse
   input wire [NOUT-1:0] clkOutEn, // output enables
   input wire [NDOM-1:0] domPowerDown // power-down
);
   timeunit 1ns;
   timeprecision 1ps;
   wire inRst = porActive || !external_reset_low; // either source holds reset
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_reset_quiet: assert property (inRst |=> !otpReq && !eepReq && !imgWe && !serialEnable && !pllStart)
      else $error("activity in reset");
   a_reset_outs: assert property (inRst |=> clkOutEn == '0 && domPowerDown == '0 && !divSync)
      else $error("outputs live in reset");
   a_fetch_gated: assert property ((otpReq || eepReq) |-> !serialEnable)
      else $error("port open while loading");
   a_lock_start: assert property ($rose(pllStart) |-> serialEnable)
      else $error("lock start before load");
   a_sync_lock: assert property (pllStart && $rose(pllLocked) |-> ##[0:4] divSync)
      else $error("no divider sync");
   a_sync_cause: assert property (divSync |-> pllLocked && pllStart)
      else $error("sync without lock");
   a_eep_range: assert property (eepReq |-> eepAddr >= `RSCL_OTP_FIRST && eepAddr <= `RSCL_EEP_CRC)
      else $error("eeprom offset out of range");
   a_img_range: assert property (imgWe |-> imgAddr <= `RSCL_IMG_LAST)
      else $error("image write past end");
   a_dom_gate: assert property (domPowerDown[8] && $past(domPowerDown[8], 2) |-> clkOutEn[9:8] == 2'b00)
      else $error("domain eight outputs on");
   c_sync: cover property (divSync);
   c_crc: cover property (eepReq && eepAddr == `RSCL_EEP_CRC);
   c_last: cover property (imgWe && imgAddr == `RSCL_IMG_LAST);
endmodule // rscl_loader_monitor
bind rscl_loader rscl_loader_monitor #(.NDOM(NDOM), .NOUT(NOUT)) u_mon (.mclk(mclk), .resetn(resetn),
   .porActive(porActive), .external_reset_low(external_reset_low), .otpReq(otpReq), .eepReq(eepReq),
   .eepAddr(eepAddr), .imgWe(imgWe), .imgAddr(imgAddr), .serialEnable(serialEnable), .pllStart(pllStart),
   .pllLocked(pllLocked), .divSync(divSync), .clkOutEn(clkOutEn), .domPowerDown(domPowerDown));

// ==== dv/test_reset_and_startup_config_loader.sv ====
/* self-checking bench of the start-up sequencer
   assumes the far-side model and the bound checker */
`include "rscl_consts.vh"
module test_reset_and_startup_config_loader;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
      $display("Error %s expected %0h seen %0h", n, e, s); end end
   logic mclk, resetn, porActive, external_reset_low, otpReq, otpValid, eepReq, eepValid, eepNack;
   logic imgWe, serialEnable, pllStart, pllLocked, divSync, psel, penable, pwrite, pready, pslverr;
   logic bootEep, slow, badCrc, err;
   logic [7:0] otpAddr, otpData, eepAddr, eepData, imgAddr, imgData, nackAt;
   logic [6:0] eepDevAddr;
   logic [11:0] clkOutEn, paddr;
   logic [9:0] domPowerDown;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] img [256]; // image as written
   int failures = 0;
   int total_checks = 0;
   int eepCnt = 0;
   rscl_loader i_rscl_loader (.mclk, .resetn, .porActive, .external_reset_low, .otpReq, .otpAddr, .otpValid,
      .otpData, .eepReq, .eepAddr, .eepDevAddr, .eepValid, .eepNack, .eepData, .imgWe, .imgAddr, .imgData,
      .serialEnable, .pllStart, .pllLocked, .divSync, .clkOutEn, .domPowerDown, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr);
   rscl_far_model u_far (.mclk, .bootEep, .slow, .badCrc, .nackAt, .otpReq, .otpAddr, .otpValid, .otpData,
      .eepReq, .eepAddr, .eepValid, .eepNack, .eepData);
   // image capture and eeprom fetch count
   always @(posedge mclk) begin
      if (imgWe === 1'b1) img[imgAddr] <= imgData;
      if (eepReq === 1'b1) eepCnt++;
   end
   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // one apb transfer; data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin `CHK("ready", 1'b1, pready) summarize(); end
      @(posedge mclk);
   endtask
   // one reset and boot pass, then lock and power-down
   task automatic run(input logic be, input logic sl, input logic bc, input logic [7:0] na);
      int n;
      logic ab;
      ab = be && (bc || na != 8'h00);
      bootEep <= be;
      slow <= sl;
      badCrc <= bc;
      nackAt <= na;
      pllLocked <= 1'b0;
      porActive <= 1'b1;
      external_reset_low <= 1'b0;
      @(posedge mclk);
      apb(1'b1, `RSCL_OFF_PDN, 32'h3FF);
      apb(1'b0, `RSCL_OFF_STAT, 32'h0);
      `CHK("status in reset", 32'h0, rd)
      apb(1'b0, `RSCL_OFF_PDN, 32'h0);
      `CHK("powerdown in reset", 32'h0, rd)
      apb(1'b0, `RSCL_OFF_DATA, 32'h0);
      `CHK("last offset in reset", 32'h0, rd)
      img[8'h20] = 8'h00;
      eepCnt = 0;
      external_reset_low <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK("port under por", 1'b0, serialEnable)
      porActive <= 1'b0;
      n = 0;
      while (serialEnable !== 1'b1 && n < 5000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 5000) begin `CHK("load done", 1'b1, serialEnable) summarize(); end
      apb(1'b0, `RSCL_OFF_STAT, 32'h0);
      `CHK("status", {27'h0, be && !ab, ab, 3'b001}, rd)
      `CHK("eeprom fetches", be ? (na != 0 ? na - 7 : 173) : 0, eepCnt)
      apb(1'b0, `RSCL_OFF_DATA, 32'h0);
      `CHK("last eeprom offset", be ? (na != 8'h00 ? na - 8'h01 : `RSCL_EEP_CRC) : 8'h00, rd)
      if (be) `CHK("eeprom bus address", 7'h50, eepDevAddr)
      if (!ab) `CHK("image byte", be ? 8'h1C : 8'h85, img[8'h20])
      apb(1'b0, `RSCL_OFF_CTRL, 32'h0);
      `CHK("control", {30'h0, 1'b1, be}, rd)
      pllLocked <= 1'b1;
      repeat (5) @(posedge mclk);
      `CHK("outputs on", 12'hFFF, clkOutEn)
      apb(1'b0, `RSCL_OFF_STAT, 32'h0);
      `CHK("status locked", {27'h0, be && !ab, ab, 3'b111}, rd)
      apb(1'b1, `RSCL_OFF_STAT, 32'hA);
      apb(1'b0, `RSCL_OFF_STAT, 32'h0);
      `CHK("status after clear", {27'h0, be && !ab, 4'b0111}, rd)
      apb(1'b1, `RSCL_OFF_PDN, 32'h100);
      repeat (2) @(posedge mclk);
      `CHK("domain eight off", 12'hCFF, clkOutEn)
      apb(1'b1, 12'h020, 32'h1);
      `CHK("unmapped error", 1'b1, err)
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped read", 32'h0, rd)
      apb(1'b1, `RSCL_OFF_CFG, 32'h33);
      apb(1'b0, `RSCL_OFF_CFG, 32'h0);
      `CHK("config overwrite", 32'h33, rd)
      apb(1'b1, `RSCL_OFF_CTRL, 32'h0);
      repeat (2) @(posedge mclk);
      `CHK("outputs off", 12'h000, clkOutEn)
   endtask
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // otp boot, eeprom refusal, bad checksum, slow eeprom boot
   initial begin
      resetn = 1'b0;
      porActive = 1'b1;
      external_reset_low = 1'b0;
      pllLocked = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      bootEep = 1'b0;
      slow = 1'b0;
      badCrc = 1'b0;
      nackAt = 8'h00;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      for (int t = 0; t < 4; t++) begin
         run(t > 0, t == 3, t == 2, t == 1 ? 8'h10 : 8'h00);
         $display("test %0d done", t);
      end
      summarize();
   end
endmodule // test_reset_and_startup_config_loader

// ==== rtl/rscl_consts.vh ====
/*
 holds the constants of the reset and start-up configuration loader:
 register offsets, field positions, reset values and timing counts.
 assumes inclusion by bare name from design and bench files.
*/
`ifndef RSCL_CONSTS_VH
`define RSCL_CONSTS_VH

// apb register offsets (byte addresses)
`define RSCL_OFF_CTRL 12'h000
`define RSCL_OFF_STAT 12'h004
`define RSCL_OFF_PDN 12'h008
`define RSCL_OFF_CFG 12'h00C
`define RSCL_OFF_DATA 12'h010

// control register fields
`define RSCL_CTRL_BOOTEEP 0
`define RSCL_CTRL_OUTEN 1

// status register fields
`define RSCL_STAT_DONE 0
`define RSCL_STAT_LOCK 1
`define RSCL_STAT_SYNCD 2
`define RSCL_STAT_ABORT 3
`define RSCL_STAT_EEPLD 4

// reset values
`define RSCL_PDN_RST 10'h000
`define RSCL_CFG_RST 8'h00

// image sizes: first block, full image, checksum position
`define RSCL_OTP_FIRST 8'h08
`define RSCL_IMG_LAST 8'hB3
`define RSCL_EEP_CRC 8'hB4

// minimum external reset pulse width in ns, and clock period in ns
`define RSCL_RST_MIN_NS 10
`define RSCL_CLK_NS 25
// least time rounds up, never below one cycle
`define RSCL_RST_MIN_CYC (((`RSCL_RST_MIN_NS + `RSCL_CLK_NS - 1) / `RSCL_CLK_NS) < 1 ? 1 : \
   ((`RSCL_RST_MIN_NS + `RSCL_CLK_NS - 1) / `RSCL_CLK_NS))

`endif

// ==== rtl/rscl_crc8.v ====
/*
 holds a byte-serial crc-8 (poly 0x07) engine used to check an eeprom image.
 assumes one clock and a synchronous clear from the sequencer.
*/
`include "rscl_consts.vh"

module rscl_crc8 (
   input wire mclk, // system clock
   input wire resetn, // async reset, active low
   input wire crcClear, // restart the checksum
   input wire crcEn, // fold in one byte
   input wire [7:0] crcByte, // byte to fold in
   output reg [7:0] crcVal_r // running checksum
);

   // one byte through the polynomial, msb first
   function [7:0] crcStep;
      input [7:0] c;
      input [7:0] d;
      integer i;
      reg [7:0] x;
      begin
         x = c ^ d;
         for (i = 0; i < 8; i = i + 1) begin
            x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
         end
         crcStep = x;
      end
   endfunction

   // clear wins over a byte in the same cycle: a new image starts fresh
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         crcVal_r <= 8'h00;
      end else if (crcClear) begin
         crcVal_r <= 8'h00;
      end else if (crcEn) begin
         crcVal_r <= crcStep(crcVal_r, crcByte);
      end
   end

endmodule // rscl_crc8

// ==== rtl/rscl_loader.v ====
/*
 holds the start-up sequencer: reset hold, otp load, optional eeprom
 boot with checksum, serial-port gating, pll lock start, divider sync,
 output-domain power-down, and an apb register slave.
 assumes otp and eeprom readers answer one byte per request with a
 valid pulse, and that the pll lock input is synchronous to mclk.
*/
// Implementation choices: the address map and the APB register port.
`include "rscl_consts.vh"

// What this block does
// - reset while power-up reset or pin asserted
// - registers held at defaults during reset
// - state machines held in initial state
// - serial port ignores accesses during reset
// - clock outputs disabled during reset
// - alarm status bits cleared during reset
// - leave reset after both resets released
// - first load initial block from otp
// - loaded boot bit chooses eeprom or otp
// - eeprom values overwrite otp values
// - serve port, start lock after loading
// - sync output dividers once pll locks
// - host may overwrite registers after init
// - per-output-domain power-down only
// - eeprom boot requests bus as master
// - no serial answers during eeprom boot
// - nack or bad checksum aborts, sets flag
module rscl_loader #(
   parameter NDOM = 10, // number of output power domains
   parameter NOUT = 12 // number of clock outputs
) (
   input wire mclk, // system clock, 40 mhz
   input wire resetn, // async system reset, active low
   input wire porActive, // internal power-up reset, active high
   input wire external_reset_low, // external reset pin, active low
   output reg otpReq, // request one otp byte
   output reg [7:0] otpAddr, // otp byte address
   input wire otpValid, // otp byte ready pulse
   input wire [7:0] otpData, // otp byte
   output reg eepReq, // request one eeprom byte
   output reg [7:0] eepAddr, // eeprom byte offset
   output reg [6:0] eepDevAddr, // eeprom bus address
   input wire eepValid, // eeprom byte ready pulse
   input wire eepNack, // eeprom read not acknowledged
   input wire [7:0] eepData, // eeprom byte
   output reg imgWe, // image write strobe
   output reg [7:0] imgAddr, // image write address
   output reg [7:0] imgData, // image write data
   output wire serialEnable, // serial port may answer
   output reg pllStart, // start pll lock attempt
   input wire pllLocked, // pll lock report
   output reg divSync, // one-cycle divider sync pulse
   output reg [NOUT-1:0] clkOutEn, // clock output enables
   output reg [NDOM-1:0] domPowerDown, // output domain power-down
   input wire [11:0] paddr, // apb address
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output wire pready, // apb ready
   output wire pslverr // apb error
);

   // state codes, one-hot
   localparam S_RST = 7'b0000001; // held in reset
   localparam S_OTP1 = 7'b0000010; // loading initial otp block
   localparam S_OTP2 = 7'b0000100; // loading rest from otp
   localparam S_EEP = 7'b0001000; // loading from eeprom
   localparam S_CRC = 7'b0010000; // reading stored checksum
   localparam S_LOCK = 7'b0100000; // waiting for pll lock
   localparam S_RUN = 7'b1000000; // running, dividers synced

   reg [6:0] state_r; // sequencer state
   reg [6:0] state_nxt; // next sequencer state
   reg waitByte_r; // a byte request is outstanding
   reg [7:0] ctrl_r; // startup control image
   reg [7:0] cfg_r; // eeprom bus address image
   reg cfgDone_r; // configuration finished or aborted
   reg abort_r; // boot abort alarm, sticky
   reg synced_r; // dividers synchronised
   reg lockSeen_r; // lock alarm, sticky
   reg eepLoaded_r; // eeprom image accepted
   reg [7:0] lastByte_r; // last eeprom byte offset reached
   wire inReset; // combined reset condition
   wire [7:0] crcVal; // running checksum
   wire crcClear; // restart checksum
   wire crcEn; // fold one byte

   // either source of reset holds the device
   assign inReset = porActive | ~external_reset_low;

   // port answers only once configured and not in reset
   assign serialEnable = cfgDone_r & ~inReset;

   assign crcClear = (state_r == S_OTP1);
   assign crcEn = (state_r == S_EEP) & eepValid & ~eepNack;

   rscl_crc8 u_crc (
      .mclk(mclk),
      .resetn(resetn),
      .crcClear(crcClear),
      .crcEn(crcEn),
      .crcByte(eepData),
      .crcVal_r(crcVal)
   );

   // sequencer next state
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_RST: begin
            if (!inReset) begin
               state_nxt = S_OTP1;
            end
         end
         S_OTP1: begin
            // after the first block, boot bit decides the source
            if (otpValid && otpAddr == `RSCL_OTP_FIRST - 8'h01) begin
               state_nxt = ctrl_r[`RSCL_CTRL_BOOTEEP] ? S_EEP : S_OTP2;
            end
         end
         S_OTP2: begin
            if (otpValid && otpAddr == `RSCL_IMG_LAST) begin
               state_nxt = S_LOCK;
            end
         end
         S_EEP: begin
            if (eepNack) begin
               state_nxt = S_LOCK;
            end else if (eepValid && eepAddr == `RSCL_IMG_LAST) begin
               state_nxt = S_CRC;
            end
         end
         S_CRC: begin
            if (eepNack || eepValid) begin
               state_nxt = S_LOCK;
            end
         end
         S_LOCK: begin
            if (pllLocked) begin
               state_nxt = S_RUN;
            end
         end
         S_RUN: begin
            state_nxt = S_RUN;
         end
         default: begin
            state_nxt = S_RST;
         end
      endcase
      if (inReset) begin
         state_nxt = S_RST;
      end
   end

   // sequencer state and byte fetch engine
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_RST;
         waitByte_r <= 1'b0;
         otpReq <= 1'b0;
         otpAddr <= 8'h00;
         eepReq <= 1'b0;
         eepAddr <= 8'h00;
         eepDevAddr <= 7'h00;
         imgWe <= 1'b0;
         imgAddr <= 8'h00;
         imgData <= 8'h00;
         cfgDone_r <= 1'b0;
         pllStart <= 1'b0;
         divSync <= 1'b0;
         synced_r <= 1'b0;
         eepLoaded_r <= 1'b0;
         lastByte_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         otpReq <= 1'b0;
         eepReq <= 1'b0;
         imgWe <= 1'b0;
         divSync <= 1'b0;
         if (inReset) begin
            // everything back to its initial condition
            waitByte_r <= 1'b0;
            otpAddr <= 8'h00;
            eepAddr <= 8'h00;
            cfgDone_r <= 1'b0;
            pllStart <= 1'b0;
            synced_r <= 1'b0;
            eepLoaded_r <= 1'b0;
            // last offset is software-visible, so it must not survive a reset
            lastByte_r <= 8'h00;
            eepDevAddr <= 7'h00;
            imgAddr <= 8'h00;
            imgData <= 8'h00;
         end else begin
            case (state_r)
               S_OTP1, S_OTP2: begin
                  // otp byte: issue, then write into the image
                  if (!waitByte_r) begin
                     otpReq <= 1'b1;
                     waitByte_r <= 1'b1;
                  end else if (otpValid) begin
                     waitByte_r <= 1'b0;
                     imgWe <= 1'b1;
                     imgAddr <= otpAddr;
                     imgData <= otpData;
                     otpAddr <= otpAddr + 8'h01;
                     if (state_nxt == S_EEP) begin
                        eepAddr <= `RSCL_OTP_FIRST;
                        eepDevAddr <= cfg_r[6:0];
                     end
                  end
               end
               S_EEP, S_CRC: begin
                  // eeprom byte: bus master fetch, then overwrite, or in S_CRC compare with the checksum
                  if (eepNack) begin
                     waitByte_r <= 1'b0;
                  end else if (!waitByte_r) begin
                     eepReq <= 1'b1;
                     waitByte_r <= 1'b1;
                  end else if (eepValid) begin
                     waitByte_r <= 1'b0;
                     lastByte_r <= eepAddr;
                     if (state_r == S_EEP) begin
                        imgWe <= 1'b1;
                        imgAddr <= eepAddr;
                        imgData <= eepData;
                        eepAddr <= (eepAddr == `RSCL_IMG_LAST) ? `RSCL_EEP_CRC : eepAddr + 8'h01;
                     end else begin
                        eepLoaded_r <= (eepData == crcVal);
                     end
                  end
               end
               S_LOCK: begin
                  cfgDone_r <= 1'b1;
                  pllStart <= 1'b1;
                  if (pllLocked) begin
                     divSync <= 1'b1;
                     synced_r <= 1'b1;
                  end
               end
               default: begin
                  waitByte_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // abort alarm: set by nack or checksum mismatch, software clears
   // by writing one; set wins over clear, reset clears
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         abort_r <= 1'b0;
         lockSeen_r <= 1'b0;
      end else if (inReset) begin
         abort_r <= 1'b0;
         lockSeen_r <= 1'b0;
      end else begin
         if ((state_r == S_EEP || state_r == S_CRC) && eepNack) begin
            abort_r <= 1'b1;
         end else if (state_r == S_CRC && eepValid && eepData != crcVal) begin
            abort_r <= 1'b1;
         end else if (psel && penable && pwrite && paddr == `RSCL_OFF_STAT &&
               pwdata[`RSCL_STAT_ABORT]) begin
            abort_r <= 1'b0;
         end
         if (synced_r && pllLocked) begin
            lockSeen_r <= 1'b1;
         end else if (psel && penable && pwrite && paddr == `RSCL_OFF_STAT &&
               pwdata[`RSCL_STAT_LOCK]) begin
            lockSeen_r <= 1'b0;
         end
      end
   end

   // software registers; image loads mirror the startup bytes
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= 8'h00;
         cfg_r <= `RSCL_CFG_RST;
         domPowerDown <= `RSCL_PDN_RST;
      end else if (inReset) begin
         ctrl_r <= 8'h00;
         cfg_r <= `RSCL_CFG_RST;
         domPowerDown <= `RSCL_PDN_RST;
      end else if (imgWe && imgAddr == 8'h00) begin
         ctrl_r <= imgData;
      end else if (imgWe && imgAddr == 8'h01) begin
         cfg_r <= imgData;
      end else if (cfgDone_r && psel && penable && pwrite) begin
         // overwrites allowed only after initialisation
         case (paddr)
            `RSCL_OFF_CTRL: ctrl_r <= pwdata[7:0];
            `RSCL_OFF_CFG: cfg_r <= pwdata[7:0];
            `RSCL_OFF_PDN: domPowerDown <= pwdata[NDOM-1:0];
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end

   // outputs open only when synced; powered-down domains stay off.
   // domains 0..7 own one output, 8 and 9 own two each
   always @(posedge mclk or negedge resetn) begin : outEnProc
      integer k;
      if (!resetn) begin
         clkOutEn <= {NOUT{1'b0}};
      end else begin
         for (k = 0; k < NOUT; k = k + 1) begin
            clkOutEn[k] <= ~inReset & synced_r & ctrl_r[`RSCL_CTRL_OUTEN] &
               ~domPowerDown[(k < 8) ? k : 8 + (k - 8) / 2];
         end
      end
   end

   // apb read mux; zero wait states
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~(paddr == `RSCL_OFF_CTRL || paddr == `RSCL_OFF_STAT ||
      paddr == `RSCL_OFF_PDN || paddr == `RSCL_OFF_CFG || paddr == `RSCL_OFF_DATA);

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `RSCL_OFF_CTRL: prdata <= {24'h000000, ctrl_r};
            `RSCL_OFF_STAT: prdata <= {27'h0000000, eepLoaded_r, abort_r, synced_r, lockSeen_r, cfgDone_r};
            `RSCL_OFF_PDN: prdata <= {{(32-NDOM){1'b0}}, domPowerDown};
            `RSCL_OFF_CFG: prdata <= {24'h000000, cfg_r};
            `RSCL_OFF_DATA: prdata <= {24'h000000, lastByte_r};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

endmodule // rscl_loader
